//--- hdl/afm_defines.svh
// constants for the alarm and foldback manager
`ifndef AFM_DEFINES_SVH
`define AFM_DEFINES_SVH

`define ALM_AC 4'h0
`define ALM_FOLD 4'h8
`define ALM_FLASH_BOOT 4'hC
`define ALM_FLASH_RECALL 4'hD
`define ALM_NONE 4'hF
`define MASKABLE 14'h070E
`define LATCHABLE 14'h0107
`define ALWAYS_LATCH 14'h00C0
`define FAN_BITS 14'h0018
`define AUTO_CLEAR 14'h0E3A
`define MASK_RST 14'h070E
`define LATCH_RST 14'h0000
`define TIMEOUT_RST 8'h05

`define REG_CTRL 8'h00
`define REG_MASK 8'h04
`define REG_LATCH 8'h08
`define REG_FOLD 8'h0C
`define REG_TIMEOUT 8'h10
`define REG_STATUS 8'h14
`define REG_ERRCNT 8'h18

`define CLK_PERIOD_NS 10
`define TICK_NS 50000000
`define TICK_MS 50
`define HOLD_MS 3000
`define TICKS_PER_S 13'h0014
`define FOLD_FINE_CODES 8'h5B
`define FOLD_FINE_BASE 13'h000A
`define FOLD_COARSE_OFS 13'h0055
`define FOLD_CODE_MAX 8'h87

`endif

//--- hdl/afm_pkg.sv
// types shared by the alarm and foldback manager
package afm_pkg;
  typedef enum logic [1:0] {
    FOLD_NONE = 2'b00,
    FOLD_CV = 2'b01,
    FOLD_CC = 2'b10
  } fold_mode_e;

  typedef logic [13:0] alarm_vec_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } avmm_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avmm_rsp_s;

  typedef struct packed {
    logic knob;
    logic out_btn;
    logic soft_keys;
    logic cv;
    logic cc;
    logic boot_fail;
    logic [11:0] cause;
  } panel_pins_s;

  typedef struct packed {
    panel_pins_s sync1;
    panel_pins_s sync2;
    logic [22:0] tick_cnt;
    logic tick;
    logic knob_q;
    logic btn_q;
    logic mode_q;
    fold_mode_e fold;
    logic [7:0] fold_code;
    logic commit;
    alarm_vec_t mask;
    alarm_vec_t latch;
    logic [7:0] timeout;
    logic remote_clr;
    alarm_vec_t active;
    logic sticky;
    logic out_want;
    logic out_en;
    logic [3:0] disp;
    logic confirm;
    logic fold_ind;
    logic err_push;
    logic recall_apply;
    logic [15:0] err_cnt;
    logic wait_rq;
    logic [31:0] rdata;
  } afm_state_s;
endpackage

//--- hdl/tick_timer.sv
// down-counting timer paced by a slow tick enable
`timescale 1ns/1ns
module tick_timer #(
  parameter int W = 13
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic start_i,
  input wire logic cancel_i,
  input wire logic [W-1:0] load_i,
  output logic running_o,
  output logic expire_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
    logic exp;
  } timer_state_s;

  timer_state_s s_ff;
  timer_state_s nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.exp = 1'b0;
    if (cancel_i) begin
      nxt_s.run = 1'b0;
    end else if (start_i) begin
      nxt_s.run = 1'b1;
      nxt_s.cnt = load_i;
    end else if (s_ff.run && tick_i) begin
      // a zero load expires on the first tick
      if (s_ff.cnt <= W'(1)) begin
        nxt_s.run = 1'b0;
        nxt_s.exp = 1'b1;
      end else begin
        nxt_s.cnt = s_ff.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign running_o = s_ff.run;
  assign expire_o = s_ff.exp;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  start_runs_a: assert property (start_i && !cancel_i |=> running_o) else $error("timer did not start");
  cancel_stops_a: assert property (cancel_i |=> !running_o && !expire_o) else $error("cancelled timer ran");
endmodule

//--- hdl/alarm_foldback_manager.sv
// protection alarm supervisor with foldback timer and avalon register slave
`timescale 1ns/1ns
`include "afm_defines.svh"
module alarm_foldback_manager #(
  parameter int TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire afm_pkg::avmm_req_s avm_req_i,
  output afm_pkg::avmm_rsp_s avm_rsp_o,
  input wire afm_pkg::panel_pins_s panel_i,
  input wire logic recall_req_i,
  input wire logic recall_cksum_bad_i,
  output logic output_enable_o,
  output logic sticky_alarm_indicator_o,
  output afm_pkg::alarm_vec_t alarm_active_o,
  output logic [3:0] displayed_alarm_o,
  output logic clear_confirm_message_o,
  output logic foldback_indicator_o,
  output logic error_push_o,
  output logic recall_apply_o
);
  import afm_pkg::*;

  localparam logic [12:0] HOLD_TICKS = 13'(`HOLD_MS / `TICK_MS);

  logic [1:0] rst_pipe_ff;
  logic rst_n;
  afm_state_s s_ff;
  afm_state_s nxt_s;
  panel_pins_s pin;
  logic knob_rise;
  logic btn_rise;
  logic in_mode;
  logic fold_start;
  logic fold_cancel;
  logic [12:0] fold_load;
  logic [12:0] recall_load;
  logic hold_exp;
  logic fold_exp;
  logic fold_run;
  logic recall_exp;
  logic recall_bad;
  alarm_vec_t mask_eff;
  alarm_vec_t latch_eff;
  alarm_vec_t trig;
  alarm_vec_t clearable;
  alarm_vec_t man_clr;
  alarm_vec_t auto_clr;
  alarm_vec_t cleared;
  logic clr_req;
  logic sticky_clr;
  logic [31:0] rd;

  // =====================================================
  // reset release
  // =====================================================
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe_ff <= 2'h0;
    end else begin
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_ff[1];

  // =====================================================
  // timers
  // =====================================================
  tick_timer #(.W(13)) hold_timer (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .tick_i(s_ff.tick),
    .start_i(knob_rise),
    .cancel_i(!pin.knob),
    .load_i(HOLD_TICKS),
    .running_o(),
    .expire_o(hold_exp)
  );

  tick_timer #(.W(13)) fold_timer (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .tick_i(s_ff.tick),
    .start_i(fold_start),
    .cancel_i(fold_cancel),
    .load_i(fold_load),
    .running_o(fold_run),
    .expire_o(fold_exp)
  );

  tick_timer #(.W(13)) recall_timer (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .tick_i(s_ff.tick),
    .start_i(recall_bad),
    .cancel_i(1'b0),
    .load_i(recall_load),
    .running_o(),
    .expire_o(recall_exp)
  );

  // =====================================================
  // next state
  // =====================================================
  always_comb begin
    nxt_s = s_ff;
    rd = 32'h0;
    pin = s_ff.sync2;
    nxt_s.sync1 = panel_i;
    nxt_s.sync2 = s_ff.sync1;

    // 50 ms pacing tick for all timers
    nxt_s.tick = 1'b0;
    if (s_ff.tick_cnt == 23'(TICK_CYCLES - 1)) begin
      nxt_s.tick_cnt = 23'h0;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.tick_cnt = s_ff.tick_cnt + 23'h1;
    end

    knob_rise = pin.knob && !s_ff.knob_q;
    btn_rise = pin.out_btn && !s_ff.btn_q;
    nxt_s.knob_q = pin.knob;
    nxt_s.btn_q = pin.out_btn;

    // foldback arming; none never matches a mode
    in_mode = (s_ff.fold == FOLD_CV && pin.cv) || (s_ff.fold == FOLD_CC && pin.cc);
    nxt_s.mode_q = in_mode && s_ff.out_en;
    fold_start = (in_mode && s_ff.out_en && !s_ff.mode_q) || (s_ff.commit && in_mode && s_ff.out_en);
    fold_cancel = !(in_mode && s_ff.out_en);
    if (s_ff.fold_code < `FOLD_FINE_CODES) begin
      fold_load = `FOLD_FINE_BASE + {5'h0, s_ff.fold_code};
    end else begin
      fold_load = 13'(({5'h0, s_ff.fold_code} - `FOLD_COARSE_OFS) * `TICKS_PER_S);
    end
    recall_load = 13'({5'h0, s_ff.timeout} * `TICKS_PER_S);

    // register slave: one wait cycle, then the request is taken
    nxt_s.wait_rq = 1'b1;
    nxt_s.commit = 1'b0;
    nxt_s.remote_clr = 1'b0;
    case (avm_req_i.address)
      `REG_CTRL: rd = 32'h0;
      `REG_MASK: rd = {18'h0, s_ff.mask};
      `REG_LATCH: rd = {18'h0, s_ff.latch};
      `REG_FOLD: rd = {16'h0, s_ff.fold_code, 6'h0, s_ff.fold};
      `REG_TIMEOUT: rd = {24'h0, s_ff.timeout};
      `REG_STATUS: rd = {10'h0, fold_run, s_ff.out_en, s_ff.sticky, s_ff.disp, 1'b0, s_ff.active};
      `REG_ERRCNT: rd = {16'h0, s_ff.err_cnt};
      default: rd = 32'h0;
    endcase
    if ((avm_req_i.read || avm_req_i.write) && s_ff.wait_rq) begin
      nxt_s.wait_rq = 1'b0;
      nxt_s.rdata = rd;
    end
    if (avm_req_i.write && !s_ff.wait_rq) begin
      case (avm_req_i.address)
        `REG_CTRL: nxt_s.remote_clr = avm_req_i.writedata[0];
        `REG_MASK: nxt_s.mask = avm_req_i.writedata[13:0];
        `REG_LATCH: nxt_s.latch = avm_req_i.writedata[13:0];
        `REG_FOLD: begin
          if (avm_req_i.writedata[1:0] == 2'h3) begin
            nxt_s.fold = FOLD_NONE;
          end else begin
            nxt_s.fold = fold_mode_e'(avm_req_i.writedata[1:0]);
          end
          // out-of-range codes pin to the 50 s ceiling
          if (avm_req_i.writedata[15:8] > `FOLD_CODE_MAX) begin
            nxt_s.fold_code = `FOLD_CODE_MAX;
          end else begin
            nxt_s.fold_code = avm_req_i.writedata[15:8];
          end
          nxt_s.commit = 1'b1;
        end
        `REG_TIMEOUT: nxt_s.timeout = avm_req_i.writedata[7:0];
        default: ;
      endcase
    end

    // alarm sources; non-maskable bits stay enabled whatever is written
    // new mask applies in the write cycle so no masked bit outlives it
    mask_eff = nxt_s.mask | ~`MASKABLE;
    latch_eff = (s_ff.latch & `LATCHABLE) | `ALWAYS_LATCH;
    recall_bad = recall_req_i && recall_cksum_bad_i;
    trig = {2'b00, pin.cause};
    trig[`ALM_FOLD] = pin.cause[`ALM_FOLD] || fold_exp;
    trig[`ALM_FLASH_BOOT] = pin.boot_fail;
    trig[`ALM_FLASH_RECALL] = recall_bad;
    trig = trig & mask_eff;

    // manual or remote clear takes the top clearable alarm only
    clr_req = hold_exp || s_ff.remote_clr;
    clearable = s_ff.active;
    clearable[`ALM_FLASH_BOOT] = 1'b0;
    man_clr = clr_req ? (clearable & alarm_vec_t'(~clearable + 14'h1)) : 14'h0;
    auto_clr = s_ff.active & `AUTO_CLEAR & ~{2'b00, pin.cause};
    cleared = man_clr | auto_clr;
    cleared[`ALM_FLASH_BOOT] = pin.soft_keys;
    cleared[`ALM_FLASH_RECALL] = cleared[`ALM_FLASH_RECALL] || recall_exp;
    cleared = cleared & s_ff.active;
    // a new trigger in the clearing cycle survives
    nxt_s.active = ((s_ff.active & ~cleared) | trig) & mask_eff;

    // output control
    if (|(cleared & latch_eff)) begin
      nxt_s.out_want = 1'b0;
    end
    if (btn_rise) begin
      nxt_s.out_want = !s_ff.out_en;
    end
    nxt_s.out_en = nxt_s.out_want && !(|(nxt_s.active & ~`FAN_BITS));

    // sticky indicator; setting wins over clearing
    sticky_clr = (s_ff.remote_clr || (btn_rise && !s_ff.out_en) || (|man_clr)) && !(|nxt_s.active);
    nxt_s.sticky = (s_ff.sticky && !sticky_clr) || (|trig);

    // lowest set bit is the displayed alarm
    nxt_s.disp = `ALM_NONE;
    for (int i = 13; i >= 0; i--) begin
      if (nxt_s.active[i]) begin
        nxt_s.disp = 4'(i);
      end
    end
    if (hold_exp && (|man_clr)) begin
      nxt_s.confirm = 1'b1;
    end else if (!pin.knob) begin
      nxt_s.confirm = 1'b0;
    end
    nxt_s.fold_ind = nxt_s.fold != FOLD_NONE;

    // user slot recall: a bad checksum keeps settings and queues an error
    nxt_s.err_push = 1'b0;
    nxt_s.recall_apply = 1'b0;
    if (recall_req_i) begin
      if (recall_cksum_bad_i) begin
        nxt_s.err_push = 1'b1;
        nxt_s.err_cnt = s_ff.err_cnt + 16'h1;
      end else begin
        nxt_s.recall_apply = 1'b1;
      end
    end
  end

  // power cycle returns every alarm to clear
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.mask <= `MASK_RST;
      s_ff.latch <= `LATCH_RST;
      s_ff.timeout <= `TIMEOUT_RST;
      s_ff.fold <= FOLD_NONE;
      s_ff.disp <= `ALM_NONE;
      s_ff.wait_rq <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // =====================================================
  // outputs
  // =====================================================
  assign avm_rsp_o = '{readdata: s_ff.rdata, waitrequest: s_ff.wait_rq};
  assign output_enable_o = s_ff.out_en;
  assign sticky_alarm_indicator_o = s_ff.sticky;
  assign alarm_active_o = s_ff.active;
  assign displayed_alarm_o = s_ff.disp;
  assign clear_confirm_message_o = s_ff.confirm;
  assign foldback_indicator_o = s_ff.fold_ind;
  assign error_push_o = s_ff.err_push;
  assign recall_apply_o = s_ff.recall_apply;

  // =====================================================
  // checks
  // =====================================================
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  alarm_blocks_output_a: assert property (!(s_ff.out_en && |(s_ff.active & ~`FAN_BITS)))
    else $error("output on while alarm active");
  indicator_follows_a: assert property (|s_ff.active |-> s_ff.sticky)
    else $error("alarm without indicator");
  mask_blocks_a: assert property (!(|(s_ff.active & ~(s_ff.mask | ~`MASKABLE))))
    else $error("masked alarm active");
  single_clear_a: assert property (clr_req |-> $countones(man_clr) <= 1)
    else $error("more than one alarm cleared");
  boot_flash_kept_a: assert property (s_ff.active[`ALM_FLASH_BOOT] && !pin.soft_keys |=> s_ff.active[`ALM_FLASH_BOOT])
    else $error("boot checksum alarm lost");
  latch_keeps_off_a: assert property (|(cleared & latch_eff) && !btn_rise |=> !s_ff.out_want)
    else $error("latched alarm let output back");
  fold_expiry_a: assert property (fold_exp && mask_eff[`ALM_FOLD] |=> s_ff.active[`ALM_FOLD] && !s_ff.out_en)
    else $error("foldback expiry missed");
  fold_none_idle_a: assert property ((s_ff.fold == FOLD_NONE)[*2] |-> !fold_run)
    else $error("foldback timer with trigger none");
  recall_error_a: assert property (recall_bad |=> s_ff.err_push && !s_ff.recall_apply)
    else $error("bad recall not refused");
  auto_keeps_led_a: assert property (|auto_clr && s_ff.sticky && !sticky_clr |=> s_ff.sticky)
    else $error("indicator dropped on auto clear");
  display_top_a: assert property (s_ff.active[`ALM_AC] |-> s_ff.disp == `ALM_AC)
    else $error("ac fail not displayed");
endmodule

//--- test/afm_panel_model.sv
// front panel model: holds the adjust knob or taps the output button on request
`timescale 1ns/1ns
module afm_panel_model #(
  parameter int HOLD_CYC = 700
) (
  input wire logic clock_i,
  input wire afm_pkg::panel_pins_s pins_i,
  input wire logic knob_req_i,
  input wire logic btn_req_i,
  output afm_pkg::panel_pins_s panel_o
);
  import afm_pkg::*;
  int kcnt = 0;
  int bcnt = 0;
  // ==========================================
  // press timing
  // knob stays down past the 3 s hold so the clear is seen before release
  always @(posedge clock_i) begin
    if (knob_req_i) kcnt <= HOLD_CYC;
    else if (kcnt > 0) kcnt <= kcnt - 1;
    if (btn_req_i) bcnt <= 4;
    else if (bcnt > 0) bcnt <= bcnt - 1;
  end
  always_comb begin
    panel_o = pins_i;
    panel_o.knob = (kcnt > 0);
    panel_o.out_btn = (bcnt > 0);
  end
endmodule

//--- test/tb_alarm_foldback_manager.sv
// self-checking bench for the alarm and foldback manager
`timescale 1ns/1ns
module tb_alarm_foldback_manager;
  import afm_pkg::*;
  logic clock_i = 0;
  logic rst_n_i = 0;
  avmm_req_s req = '0;
  avmm_rsp_s rsp;
  panel_pins_s pins = '0;
  panel_pins_s pan;
  logic knob_req = 0;
  logic btn_req = 0;
  logic rc_req = 0;
  logic rc_bad = 0;
  logic out_en, sticky, confirm, fold_ind, push, apply;
  alarm_vec_t act;
  logic [3:0] disp;
  logic [31:0] exp_q[$];
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  int n_push = 0;
  int n_apply = 0;
  logic [7:0] tv;

  always #5 clock_i = ~clock_i;

  afm_panel_model #(.HOLD_CYC(700)) panel_u (.clock_i(clock_i), .pins_i(pins), .knob_req_i(knob_req),
    .btn_req_i(btn_req), .panel_o(pan));

  alarm_foldback_manager #(.TICK_CYCLES(10)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .avm_req_i(req),
    .avm_rsp_o(rsp), .panel_i(pan), .recall_req_i(rc_req), .recall_cksum_bad_i(rc_bad),
    .output_enable_o(out_en), .sticky_alarm_indicator_o(sticky), .alarm_active_o(act),
    .displayed_alarm_o(disp), .clear_confirm_message_o(confirm), .foldback_indicator_o(fold_ind),
    .error_push_o(push), .recall_apply_o(apply));

  // ==========================================
  // checking
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic st(input logic [13:0] a, input logic [3:0] d, input logic s, input logic o);
    chk("active", 32'(a), 32'(act));
    chk("displayed", 32'(d), 32'(disp));
    chk("indicator", 32'(s), 32'(sticky));
    chk("output", 32'(o), 32'(out_en));
  endtask

  // read data is compared at the accepting edge against the oldest note
  always @(posedge clock_i) begin
    cycles++;
    if (push === 1'b1) n_push++;
    if (apply === 1'b1) n_apply++;
    if (req.read === 1'b1 && rsp.waitrequest === 1'b0) begin
      if (exp_q.size() == 0) chk("read queue", 32'h1, 32'h0);
      else chk("readdata", exp_q.pop_front(), rsp.readdata);
    end
    if (cycles == 30000) begin
      n_errors++;
      final_report();
    end
  end

  // ==========================================
  // stimulus helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // one avalon access; a read notes d as its expected data
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    req.read <= !wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= wr ? d : 32'h0;
    if (!wr) exp_q.push_back(d);
    do @(posedge clock_i); while (rsp.waitrequest !== 1'b0);
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic knob();
    knob_req <= 1'b1;
    @(posedge clock_i);
    knob_req <= 1'b0;
    cyc(660);
  endtask

  task automatic btn();
    btn_req <= 1'b1;
    @(posedge clock_i);
    btn_req <= 1'b0;
    cyc(12);
  endtask

  task automatic cause(input int b);
    pins.cause[b] <= 1'b1;
    cyc(8);
    pins.cause[b] <= 1'b0;
    cyc(8);
  endtask

  task automatic endt(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(75));
    cyc(10);
    rst_n_i <= 1'b1;
    cyc(3);
    bus(0, 8'h04, 32'h0000070E);
    bus(0, 8'h08, 32'h0);
    bus(0, 8'h10, 32'h5);
    bus(0, 8'h0C, 32'h0);
    bus(1, 8'h1C, 32'hFFFF);
    bus(0, 8'h1C, 32'h0);
    tv = 8'($urandom_range(255, 1));
    bus(1, 8'h10, 32'(tv));
    bus(0, 8'h10, 32'(tv));
    bus(1, 8'h10, 32'h1);
    st(14'h0, 4'hF, 1'b0, 1'b0);
    endt("registers");
    btn();
    chk("output", 32'h1, 32'(out_en));
    pins.cause[0] <= 1'b1;
    pins.cause[6] <= 1'b1;
    cyc(8);
    pins.cause <= 12'h0;
    cyc(8);
    st(14'h0041, 4'h0, 1'b1, 1'b0);
    knob();
    st(14'h0040, 4'h6, 1'b1, 1'b0);
    chk("confirm", 32'h1, 32'(confirm));
    cyc(60);
    knob();
    st(14'h0, 4'hF, 1'b0, 1'b0);
    cyc(60);
    endt("precedence");
    btn();
    cause(3);
    st(14'h0, 4'hF, 1'b1, 1'b1);
    bus(1, 8'h00, 32'h1);
    cyc(2);
    chk("indicator", 32'h0, 32'(sticky));
    endt("auto clear");
    bus(1, 8'h04, 32'h0);
    pins.cause[10] <= 1'b1;
    cyc(8);
    st(14'h0, 4'hF, 1'b0, 1'b1);
    pins.cause[10] <= 1'b0;
    bus(1, 8'h04, 32'h00000400);
    pins.cause[10] <= 1'b1;
    cyc(8);
    st(14'h0400, 4'hA, 1'b1, 1'b0);
    pins.cause[10] <= 1'b0;
    cyc(8);
    st(14'h0, 4'hF, 1'b1, 1'b1);
    bus(1, 8'h04, 32'h0000070E);
    btn();
    btn();
    st(14'h0, 4'hF, 1'b0, 1'b1);
    endt("mask");
    bus(1, 8'h08, 32'h00000100);
    bus(1, 8'h0C, 32'h00000001);
    chk("fold indicator", 32'h1, 32'(fold_ind));
    pins.cv <= 1'b1;
    cyc(50);
    pins.cv <= 1'b0;
    cyc(150);
    chk("active", 32'h0, 32'(act));
    pins.cv <= 1'b1;
    cyc(60);
    chk("active", 32'h0, 32'(act));
    cyc(90);
    st(14'h0100, 4'h8, 1'b1, 1'b0);
    pins.cv <= 1'b0;
    knob();
    st(14'h0, 4'hF, 1'b0, 1'b0);
    cyc(60);
    pins.cc <= 1'b1;
    btn();
    bus(1, 8'h0C, 32'h00005A02);
    bus(0, 8'h14, 32'h00378000);
    bus(1, 8'h0C, 32'h0);
    bus(0, 8'h14, 32'h00178000);
    bus(1, 8'h0C, 32'h0000FF03);
    bus(0, 8'h0C, 32'h00008700);
    chk("fold indicator", 32'h0, 32'(fold_ind));
    pins.cc <= 1'b0;
    endt("foldback");
    rc_req <= 1'b1;
    rc_bad <= 1'b1;
    @(posedge clock_i);
    rc_req <= 1'b0;
    rc_bad <= 1'b0;
    cyc(6);
    st(14'h2000, 4'hD, 1'b1, 1'b0);
    chk("error pushes", 32'h1, 32'(n_push));
    chk("applies", 32'h0, 32'(n_apply));
    bus(0, 8'h18, 32'h1);
    cyc(230);
    chk("active", 32'h0, 32'(act));
    rc_req <= 1'b1;
    @(posedge clock_i);
    rc_req <= 1'b0;
    cyc(4);
    chk("applies", 32'h1, 32'(n_apply));
    endt("recall");
    pins.boot_fail <= 1'b1;
    cyc(8);
    pins.boot_fail <= 1'b0;
    knob();
    chk("active", 32'h1000, 32'(act));
    cyc(60);
    pins.soft_keys <= 1'b1;
    cyc(8);
    pins.soft_keys <= 1'b0;
    cyc(4);
    chk("active", 32'h0, 32'(act));
    endt("boot checksum");
    cause(0);
    rst_n_i <= 1'b0;
    cyc(10);
    rst_n_i <= 1'b1;
    cyc(4);
    st(14'h0, 4'hF, 1'b0, 1'b0);
    endt("power cycle");
    final_report();
  end
endmodule
